// ### scs_cfg.svh
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
// Notes on behaviour
// - Software select overrides the select pin
// - Bit order: zero MSB first, one LSB
// - Enable bit turns the interface on
// - Baud code divides clock, 2 to 256
// - Role bit: zero slave, one master
// - Polarity bit sets serial clock idle level
// - Phase bit: sample first or second edge
// - Transmit-empty interrupt when enabled and flagged
// - Receive-not-empty interrupt when enabled and flagged
// - Any error flag interrupts when enabled
// - Select output off: pin not driven
// - Select output on as enabled master: pin driven
// - Transmit DMA request while empty flag set
// - Receive DMA request while not-empty flag set
// - Software management bit picks select source
// - Status shows transmit-empty flag

// Byte offsets of the registers
`define SCS_OFF_CTRL_ONE 4'h0
`define SCS_OFF_CTRL_TWO 4'h4
`define SCS_OFF_STATUS 4'h8
// Reset values
`define SCS_CTRL_ONE_RST 16'h0000
`define SCS_CTRL_TWO_RST 16'h0000
// Writable bits of the second register
`define SCS_CTRL_TWO_MASK 16'h00E7
// Status field positions
`define SCS_STS_TX_EMPTY 1
`define SCS_STS_RX_FULL 0
// Baud counter width, enough for half of 256
`define SCS_BAUD_CNT_W 7
`endif

// ### scs_pkg.sv
package scs_pkg;
	typedef struct packed {
		logic [5:0] upper;
		logic soft_slave_manage;
		logic internal_select;
		logic low_bit_first;
		logic port_enable;
		logic [2:0] baud_divider;
		logic role_select;
		logic clock_idle_level;
		logic clock_sample_edge;
	} scs_ctrl_one_s;
	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic tx_empty_irq_enable;
		logic rx_full_irq_enable;
		logic error_irq_enable;
		logic [1:0] rsvd_lo;
		logic select_output_enable;
		logic tx_dma_enable;
		logic rx_dma_enable;
	} scs_ctrl_two_s;
	typedef struct packed {
		logic busy;
		logic overflow;
		logic mode_fault_flag;
		logic checksum_mismatch_flag;
		logic underflow;
		logic tx_empty_flag;
		logic rx_not_empty_flag;
	} scs_flags_s;
endpackage : scs_pkg

// ### scs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module scs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage;

	if (WIDTH < 1) begin : g_chk
		$error("scs_sync: WIDTH must be at least 1");
	end

	// Two flops; idle high so a floating select reads as deselected
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			stage <= '1;
			sync_o <= '1;
		end else begin
			stage <= async_i;
			sync_o <= stage;
		end
	end
endmodule // scs_sync
`default_nettype wire

// ### scs_baud.sv
`timescale 1ns/1ns
`default_nettype none
module scs_baud #(
	parameter int CNT_W = 7
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic run_i,
	input wire logic [2:0] code_i,
	output logic tick_o
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W:0] span;
	logic [CNT_W-1:0] limit;

	if (CNT_W < 7) begin : g_chk
		$error("scs_baud: CNT_W below 7 cannot reach divide by 256");
	end

	assign span = {{CNT_W{1'b0}}, 1'b1} << code_i;
	assign limit = span[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
	assign tick_o = run_i && (cnt == limit);

	// Restart from zero so each transfer opens on a full half period
	always_ff @(posedge core_clk_i) begin
		if (reset_i || !run_i || tick_o) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
endmodule // scs_baud
`default_nettype wire

// ### scs_top.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "scs_cfg.svh"
module scs_top
	import scs_pkg::*;
#(
	parameter int BAUD_CNT_W = `SCS_BAUD_CNT_W
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire scs_flags_s flags_i,
	input wire logic slave_select_pin_i,
	output logic slave_select_pin_o,
	output logic slave_select_pin_oe_o,
	output logic select_level_o,
	output scs_ctrl_one_s ctrl_one_o,
	output scs_ctrl_two_s ctrl_two_o,
	output logic sclk_o,
	output logic sclk_oe_o,
	output logic sample_strobe_o,
	output logic irq_o,
	output logic tx_dma_req_o,
	output logic rx_dma_req_o
);
	logic pin_sync;
	logic req;
	logic next_wait;
	logic wr_commit;
	logic [3:0] addr_word;
	logic hit_one;
	logic hit_two;
	logic hit_sts;
	logic [15:0] status_word;
	logic [15:0] wr_merge_one;
	logic [15:0] wr_merge_two;
	logic [31:0] next_readdata;
	logic active;
	logic baud_tick;
	logic edge_second;
	logic err_any;
	logic next_irq;
	logic next_select;
	logic drive_select;

	if (BAUD_CNT_W < 7) begin : g_chk
		$error("scs_top: BAUD_CNT_W below 7");
	end

	// Select pin comes from outside; two flops first
	scs_sync #(
		.WIDTH(1)
	) u_pin_sync (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.async_i(slave_select_pin_i),
		.sync_o(pin_sync)
	);

	// Address decode, low two bits ignored
	assign req = avs_read_i || avs_write_i;
	assign next_wait = !(req && avs_waitrequest_o);
	assign wr_commit = avs_write_i && !avs_waitrequest_o;
	assign addr_word = {avs_address_i[3:2], 2'b00};
	assign hit_one = (addr_word == `SCS_OFF_CTRL_ONE);
	assign hit_two = (addr_word == `SCS_OFF_CTRL_TWO);
	assign hit_sts = (addr_word == `SCS_OFF_STATUS);

	// Byte lanes 0 and 1 carry the 16-bit registers
	assign wr_merge_one = {
		avs_byteenable_i[1] ? avs_writedata_i[15:8] : ctrl_one_o[15:8],
		avs_byteenable_i[0] ? avs_writedata_i[7:0] : ctrl_one_o[7:0]};
	assign wr_merge_two = `SCS_CTRL_TWO_MASK & {
		avs_byteenable_i[1] ? avs_writedata_i[15:8] : ctrl_two_o[15:8],
		avs_byteenable_i[0] ? avs_writedata_i[7:0] : ctrl_two_o[7:0]};

	// status word from the engine flags
	assign status_word = {8'h00, flags_i.busy, flags_i.overflow,
		flags_i.mode_fault_flag, flags_i.checksum_mismatch_flag,
		flags_i.underflow, 1'b0, flags_i.tx_empty_flag,
		flags_i.rx_not_empty_flag};

	// Read mux; unmapped words read zero
	assign next_readdata = hit_one ? {16'h0000, ctrl_one_o} :
		hit_two ? {16'h0000, ctrl_two_o} :
		hit_sts ? {16'h0000, status_word} : 32'h0000_0000;

	// One wait cycle: readdata loaded as waitrequest drops
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= next_wait;
			if (avs_read_i && avs_waitrequest_o) begin
				avs_readdata_o <= next_readdata;
			end
		end
	end

	// bit order stored for the engine
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl_one_o <= `SCS_CTRL_ONE_RST;
			ctrl_two_o <= `SCS_CTRL_TWO_RST;
		end else if (wr_commit && hit_one) begin
			ctrl_one_o <= wr_merge_one;
		end else if (wr_commit && hit_two) begin
			ctrl_two_o <= wr_merge_two;
		end
	end

	// clock runs only when enabled as master and busy
	assign active = ctrl_one_o.port_enable && ctrl_one_o.role_select
		&& flags_i.busy;

	// divider trusts the code to stay put mid transfer
	scs_baud #(
		.CNT_W(BAUD_CNT_W)
	) u_baud (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.run_i(active),
		.code_i(ctrl_one_o.baud_divider),
		.tick_o(baud_tick)
	);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sclk_o <= 1'b0;
			edge_second <= 1'b0;
			sample_strobe_o <= 1'b0;
		end else if (!active) begin
			sclk_o <= ctrl_one_o.clock_idle_level;
			edge_second <= 1'b0;
			sample_strobe_o <= 1'b0;
		end else if (baud_tick) begin
			sclk_o <= !sclk_o;
			edge_second <= !edge_second;
			sample_strobe_o <= (edge_second == ctrl_one_o.clock_sample_edge);
		end else begin
			sample_strobe_o <= 1'b0;
		end
	end

	assign next_select = ctrl_one_o.soft_slave_manage ?
		ctrl_one_o.internal_select : pin_sync;
	// drive select only as enabled master
	assign drive_select = ctrl_two_o.select_output_enable
		&& ctrl_one_o.port_enable && ctrl_one_o.role_select;

	assign err_any = flags_i.checksum_mismatch_flag || flags_i.overflow
		|| flags_i.underflow || flags_i.mode_fault_flag;
	assign next_irq =
		(ctrl_two_o.tx_empty_irq_enable && flags_i.tx_empty_flag) ||
		(ctrl_two_o.rx_full_irq_enable && flags_i.rx_not_empty_flag) ||
		(ctrl_two_o.error_irq_enable && err_any);

	// Registered outputs; one cycle behind the flags
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			select_level_o <= 1'b1;
			slave_select_pin_o <= 1'b1;
			slave_select_pin_oe_o <= 1'b0;
			sclk_oe_o <= 1'b0;
			irq_o <= 1'b0;
			tx_dma_req_o <= 1'b0;
			rx_dma_req_o <= 1'b0;
		end else begin
			select_level_o <= next_select;
			slave_select_pin_o <= !drive_select;
			slave_select_pin_oe_o <= drive_select;
			sclk_oe_o <= ctrl_one_o.port_enable && ctrl_one_o.role_select;
			irq_o <= next_irq;
			tx_dma_req_o <= ctrl_two_o.tx_dma_enable && flags_i.tx_empty_flag;
			rx_dma_req_o <= ctrl_two_o.rx_dma_enable && flags_i.rx_not_empty_flag;
		end
	end

	// Checking helpers: spacing of serial clock edges
	logic sclk_prev;
	logic gap_seen;
	logic [8:0] gap_cnt;
	logic [8:0] gap_want;
	assign gap_want = (9'h001 << ctrl_one_o.baud_divider) - 9'h001;
	always_ff @(posedge core_clk_i) begin
		sclk_prev <= sclk_o;
		if (reset_i || !active) begin
			gap_cnt <= 9'h000;
			gap_seen <= 1'b0;
		end else if (sclk_o != sclk_prev) begin
			gap_cnt <= 9'h000;
			gap_seen <= 1'b1;
		end else begin
			gap_cnt <= gap_cnt + 9'h001;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	property p_soft_select;
		$past(ctrl_one_o.soft_slave_manage) |->
			select_level_o == $past(ctrl_one_o.internal_select);
	endproperty
	a_soft_select: assert property (p_soft_select)
		else $error("select level ignores software bit");

	property p_pin_select;
		!$past(ctrl_one_o.soft_slave_manage) |->
			select_level_o == $past(pin_sync);
	endproperty
	a_pin_select: assert property (p_pin_select)
		else $error("select level ignores pin");

	property p_disabled_quiet;
		!ctrl_one_o.port_enable |=> !sclk_oe_o && !slave_select_pin_oe_o;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("disabled port still drives");

	property p_baud_gap;
		active && gap_seen && (sclk_o != sclk_prev) |-> gap_cnt == gap_want;
	endproperty
	a_baud_gap: assert property (p_baud_gap)
		else $error("serial clock half period wrong");

	property p_idle_level;
		!active |=> sclk_o == $past(ctrl_one_o.clock_idle_level);
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("serial clock idle level wrong");

	property p_sample_edge;
		sample_strobe_o |-> (sclk_o != sclk_prev) && (sclk_o ==
			(ctrl_one_o.clock_idle_level ^ !ctrl_one_o.clock_sample_edge));
	endproperty
	a_sample_edge: assert property (p_sample_edge)
		else $error("sample on wrong edge");

	property p_irq_tx;
		ctrl_two_o.tx_empty_irq_enable && flags_i.tx_empty_flag |=> irq_o;
	endproperty
	a_irq_tx: assert property (p_irq_tx)
		else $error("transmit empty did not interrupt");

	property p_irq_rx;
		ctrl_two_o.rx_full_irq_enable && flags_i.rx_not_empty_flag |=> irq_o;
	endproperty
	a_irq_rx: assert property (p_irq_rx)
		else $error("receive not empty did not interrupt");

	property p_irq_err;
		ctrl_two_o.error_irq_enable && err_any |=> irq_o;
	endproperty
	a_irq_err: assert property (p_irq_err)
		else $error("error did not interrupt");

	property p_irq_masked;
		!next_irq [*2] |-> !irq_o;
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt without enabled source");

	property p_select_off;
		!ctrl_two_o.select_output_enable |=> !slave_select_pin_oe_o;
	endproperty
	a_select_off: assert property (p_select_off)
		else $error("select pin driven while output off");

	property p_select_on;
		drive_select |=> slave_select_pin_oe_o && !slave_select_pin_o;
	endproperty
	a_select_on: assert property (p_select_on)
		else $error("master did not drive select");

	property p_tx_dma;
		$rose(flags_i.tx_empty_flag) && ctrl_two_o.tx_dma_enable |=> tx_dma_req_o;
	endproperty
	a_tx_dma: assert property (p_tx_dma)
		else $error("no transmit DMA request");

	property p_rx_dma;
		$rose(flags_i.rx_not_empty_flag) && ctrl_two_o.rx_dma_enable
			|=> rx_dma_req_o;
	endproperty
	a_rx_dma: assert property (p_rx_dma)
		else $error("no receive DMA request");

	property p_reserved;
		ctrl_two_o.rsvd_hi == 8'h00 && ctrl_two_o.rsvd_lo == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits set");

	property p_status_read;
		avs_read_i && !avs_waitrequest_o && hit_sts |->
			avs_readdata_o[`SCS_STS_TX_EMPTY] == $past(flags_i.tx_empty_flag);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status shows wrong transmit empty");

	property p_reset_zero;
		@(posedge core_clk_i) $past(reset_i) |->
			ctrl_one_o == 16'h0000 && ctrl_two_o == 16'h0000 && !irq_o;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("registers not cleared by reset");

	property p_wait_pulse;
		req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse)
		else $error("bus answer not one cycle");

	property p_slave_quiet;
		!ctrl_one_o.role_select |=> !sclk_oe_o && !slave_select_pin_oe_o;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet)
		else $error("slave role still drives clock or select");

	property p_tx_dma_off;
		!ctrl_two_o.tx_dma_enable |=> !tx_dma_req_o;
	endproperty
	a_tx_dma_off: assert property (p_tx_dma_off)
		else $error("transmit DMA request while disabled");

	c_soft: cover property (ctrl_one_o.soft_slave_manage && !select_level_o);
	c_sample: cover property (sample_strobe_o && ctrl_one_o.clock_sample_edge);
	c_dma: cover property (tx_dma_req_o && rx_dma_req_o);
	c_irq: cover property ($rose(irq_o));
	c_pin_drive: cover property (slave_select_pin_oe_o && !slave_select_pin_o);
endmodule // scs_top
`default_nettype wire

// ### scs_remote.sv
`timescale 1ns/1ns
`default_nettype none
// Remote party on the serial link; the select line carries a pull-up
module scs_remote (
	input wire logic sclk_i,
	input wire logic pin_o_i,
	input wire logic pin_oe_i,
	input wire logic pull_low_i,
	output logic level_o,
	output var int edges_o
);
	int seen = 0;

	assign level_o = pin_oe_i ? pin_o_i : !pull_low_i;

	// Count every clock line change, so a stray toggle while refused shows
	assign edges_o = seen;
	always @(sclk_i) begin
		seen = seen + 1;
	end
endmodule // scs_remote
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import scs_pkg::*;
;
	typedef struct packed {
		logic [15:0] wr;
		logic [6:0] fl;
		logic [15:0] rb;
		logic [2:0] o;
	} scs_row_s;
	logic core_clk_i, reset_i, avs_read_i, avs_write_i, pull_low;
	logic [3:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	logic avs_waitrequest_o, pin_o, pin_oe, level, select_level_o, sclk_o, sclk_oe_o;
	logic sample_strobe_o, irq_o, tx_dma_req_o, rx_dma_req_o;
	scs_flags_s flags_i;
	scs_ctrl_one_s ctrl_one_o;
	scs_ctrl_two_s ctrl_two_o;
	int errors = 0, checks_done = 0, cycles = 0, n, e0;
	logic [2:0] code;
	logic [3:0] be;
	// software writes zeros to reserved bits
	scs_row_s rows [0:11] = '{'{16'h00E7, 7'h03, 16'h00E7, 3'h7}, '{16'h0080, 7'h02, 16'h0080, 3'h4},
		'{16'h0040, 7'h02, 16'h0040, 3'h0}, '{16'h0040, 7'h01, 16'h0040, 3'h4},
		'{16'h0020, 7'h20, 16'h0020, 3'h4}, '{16'h0020, 7'h10, 16'h0020, 3'h4},
		'{16'h0020, 7'h08, 16'h0020, 3'h4}, '{16'h0020, 7'h04, 16'h0020, 3'h4},
		'{16'h00C0, 7'h3C, 16'h00C0, 3'h0}, '{16'h0002, 7'h03, 16'h0002, 3'h2},
		'{16'h0001, 7'h03, 16'h0001, 3'h1}, '{16'h0000, 7'h00, 16'h0000, 3'h0}};

	scs_top scs_top_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(be),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.flags_i(flags_i), .slave_select_pin_i(level), .slave_select_pin_o(pin_o),
		.slave_select_pin_oe_o(pin_oe), .select_level_o(select_level_o),
		.ctrl_one_o(ctrl_one_o), .ctrl_two_o(ctrl_two_o), .sclk_o(sclk_o),
		.sclk_oe_o(sclk_oe_o), .sample_strobe_o(sample_strobe_o), .irq_o(irq_o),
		.tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o));
	scs_remote scs_remote_inst (.sclk_i(sclk_o), .pin_o_i(pin_o),
		.pin_oe_i(pin_oe), .pull_low_i(pull_low), .level_o(level), .edges_o(e0));

	// Free-running 50 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = !core_clk_i;
	end

	// Hang guard, far above the fewer than a thousand cycles the tests need
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			check("timeout", 32'd1, 32'd0);
			final_report();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Hold the request until waitrequest is sampled low, then release
	task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= {16'h0000, d};
		do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic setf(input logic [6:0] f, input logic pl);
		@(posedge core_clk_i);
		flags_i <= f;
		pull_low <= pl;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence: reset, table rows, then the hand-written cases
	initial begin
		reset_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 4'h0;
		avs_writedata_i = 32'h0000_0000;
		flags_i = 7'h00;
		pull_low = 1'b0;
		be = 4'hF;
		repeat (4) @(posedge core_clk_i);
		reset_i <= 1'b0;
		tick(4);
		check("irq", {irq_o, tx_dma_req_o, rx_dma_req_o, pin_oe, sclk_oe_o}, 0);
		bus(0, 4'h0, 0);
		check("ctrl_one", q, 0);
		bus(0, 4'h4, 0);
		check("ctrl_two", q, 0);
		$display("test reset done");
		foreach (rows[i]) begin
			setf(rows[i].fl, 1'b0);
			bus(1, 4'h4, rows[i].wr);
			tick(2);
			check("irq_dma", {irq_o, tx_dma_req_o, rx_dma_req_o}, rows[i].o);
			check("ctrl_two_o", ctrl_two_o, rows[i].rb);
			bus(0, 4'h4, 0);
			check("ctrl_two", q, rows[i].rb);
			bus(0, 4'h8, 0);
			check("status", q, {24'h00_0000, rows[i].fl[6:2], 1'b0, rows[i].fl[1:0]});
		end
		setf(7'h00, 1'b0);
		$display("test rows done");
		foreach (rows[i]) begin
			bus(1, 4'h0, rows[i].wr ^ 16'hFF00);
			tick(1);
			check("ctrl_one_o", ctrl_one_o, rows[i].wr ^ 16'hFF00);
			bus(0, 4'h0, 0);
			check("ctrl_one", q, rows[i].wr ^ 16'hFF00);
		end
		bus(1, 4'hC, 16'hFFFF);
		bus(0, 4'hC, 0);
		check("unmapped", q, 0);
		bus(0, 4'h0, 0);
		check("ctrl_one", q, rows[11].wr ^ 16'hFF00);
		// Byte lanes written one at a time
		be <= 4'h1;
		bus(1, 4'h0, 16'h1234);
		be <= 4'h2;
		bus(1, 4'h0, 16'h5678);
		be <= 4'hF;
		bus(0, 4'h0, 0);
		check("lanes", q, 32'h0000_5634);
		$display("test ctrl one done");
		bus(1, 4'h0, 16'h0200);
		tick(4);
		check("select", select_level_o, 0);
		bus(1, 4'h0, 16'h0300);
		setf(7'h00, 1'b1);
		tick(5);
		check("select", select_level_o, 1);
		bus(1, 4'h0, 16'h0000);
		tick(5);
		check("select", select_level_o, 0);
		bus(1, 4'h4, 16'h0004);
		setf(7'h00, 1'b0);
		bus(1, 4'h0, 16'h0044);
		tick(2);
		check("pin", {pin_oe, level}, 2'b10);
		bus(1, 4'h4, 16'h0000);
		tick(2);
		check("pin", {pin_oe, level}, 2'b01);
		$display("test select done");
		for (int c = 0; c < 8; c++) begin
			code = c[2:0];
			bus(1, 4'h0, {9'h000, 1'b1, code, 1'b1, code[0], code[1]});
			tick(2);
			check("idle", sclk_o, code[0]);
			setf(7'h40, 1'b0);
			n = 0;
			do begin @(posedge core_clk_i); #1; n++; end while (sclk_o === code[0] && n < 300);
			check("first", n, 1 << c);
			check("strobe", {sclk_oe_o, sample_strobe_o}, {1'b1, !code[1]});
			n = 0;
			do begin @(posedge core_clk_i); #1; n++; end while (sclk_o !== code[0] && n < 300);
			check("half", n, 1 << c);
			check("strobe", sample_strobe_o, code[1]);
			// stop the transfer before settings change
			setf(7'h00, 1'b0);
			tick(2);
		end
		for (int c = 0; c < 2; c++) begin
			bus(1, 4'h0, c ? 16'h0004 : 16'h0040);
			setf(7'h40, 1'b0);
			// Idle level change of the write settles before the count starts
			tick(1);
			n = e0;
			tick(19);
			check("no_clock", {sclk_oe_o, 31'(e0 - n)}, 0);
			setf(7'h00, 1'b0);
		end
		$display("test serial clock done");
		bus(1, 4'h4, 16'h00E7);
		bus(1, 4'h0, 16'h0044);
		reset_i <= 1'b1;
		tick(1);
		@(posedge core_clk_i);
		reset_i <= 1'b0;
		tick(1);
		check("mid_reset_out", {avs_waitrequest_o, select_level_o, pin_oe, sclk_oe_o, irq_o,
			tx_dma_req_o, rx_dma_req_o}, 7'h60);
		tick(1);
		check("mid_reset", {ctrl_one_o, ctrl_two_o}, 0);
		bus(0, 4'h4, 0);
		check("ctrl_two", q, 0);
		$display("test second reset done");
		final_report();
	end
endmodule // tb
`default_nettype wire
